// file: verification/pdp_asserts.sv
`timescale 1ns/1ns
module pdp_asserts #(
    parameter integer PWM_PERIOD_CYC = 2000
) (
    input wire        CLK_SYS,
    input wire        RESET,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [7:0]  PADDR,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        DEMAND_OUTPUT_PORT_O,
    input wire        DEMAND_OUTPUT_PORT_OE
);
    wire setup  = PSEL && !PENABLE;
    wire ro     = PADDR == 8'h08 || PADDR == 8'h0C;
    wire mapped = ro || PADDR == 8'h00 || PADDR == 8'h04;

    // Cycles since reset, saturating once the first period has gone by.
    logic [31:0] since_rst;
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            since_rst <= 32'h0;
        end else if (since_rst < PWM_PERIOD_CYC) begin
            since_rst <= since_rst + 32'h1;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    chk_ready_setup: assert property (setup |=> PREADY)
        else $error("ready missing after setup");
    chk_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_ready_cause: assert property (PREADY |-> $past(setup))
        else $error("ready without setup");
    chk_err_unmapped: assert property (setup && !mapped |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    chk_err_readonly: assert property (setup && PWRITE && ro |=> PSLVERR)
        else $error("read-only write not refused");
    chk_ok_mapped: assert property (setup && mapped && !(PWRITE && ro) |=> !PSLVERR)
        else $error("legal access refused");
    chk_idle_quiet: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
        else $error("bus outputs busy while idle");
    chk_pin_ground: assert property (DEMAND_OUTPUT_PORT_O == 1'b0)
        else $error("pin value not ground");
    chk_reset_open: assert property (disable iff (1'b0) RESET |=> !DEMAND_OUTPUT_PORT_OE && !PREADY)
        else $error("pin or ready active after reset");
    chk_oe_min_on: assert property ($rose(DEMAND_OUTPUT_PORT_OE) |=> DEMAND_OUTPUT_PORT_OE)
        else $error("truncated grounded pulse");
    chk_oe_min_off: assert property ($fell(DEMAND_OUTPUT_PORT_OE) |=> !DEMAND_OUTPUT_PORT_OE)
        else $error("truncated released pulse");
    chk_first_open: assert property (since_rst < PWM_PERIOD_CYC |-> !DEMAND_OUTPUT_PORT_OE)
        else $error("pin grounded before first period end");

    cov_unmapped: cover property (setup && !mapped);
    cov_cal_write: cover property (PREADY && PWRITE && PADDR == 8'h04);
    cov_pin_on: cover property ($rose(DEMAND_OUTPUT_PORT_OE));
endmodule // pdp_asserts

bind pdp_top pdp_asserts #(.PWM_PERIOD_CYC(PWM_PERIOD_CYC)) pdp_asserts_inst (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DEMAND_OUTPUT_PORT_O(DEMAND_OUTPUT_PORT_O), .DEMAND_OUTPUT_PORT_OE(DEMAND_OUTPUT_PORT_OE));

// file: verification/pdp_rx.sv
`timescale 1ns/1ns
// Receiver model: times the released (high) part and the whole period of the demand pin.
module pdp_rx (
    input  wire        clk,
    input  wire        rst,
    input  wire        pin,
    output reg  [15:0] hi_len,
    output reg  [15:0] per_len,
    output reg  [15:0] n_per
);
    reg        pin_r;
    reg [15:0] cnt_r;

    // A period is taken from one rising edge of the pin to the next.
    always @(posedge clk) begin
        pin_r <= pin;
        if (rst) begin
            cnt_r   <= 16'h0000;
            hi_len  <= 16'h0000;
            per_len <= 16'h0000;
            n_per   <= 16'h0000;
        end else if (pin && !pin_r) begin
            per_len <= cnt_r;
            n_per   <= n_per + 16'h0001;
            cnt_r   <= 16'h0001;
        end else begin
            if (!pin && pin_r) begin
                hi_len <= cnt_r;
            end
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule // pdp_rx

// file: verification/test_powertrain_demand_pwm_output.sv
`timescale 1ns/1ns
`include "pdp_map.vh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module test_powertrain_demand_pwm_output;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [15:0] pedal   = 16'h0;
    logic [15:0] cruise  = 16'h0;
    logic [15:0] red     = 16'h0;
    logic [15:0] avail   = 16'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        demand_o;
    logic        demand_oe;
    logic [15:0] hi_len;
    logic [15:0] per_len;
    logic [15:0] n_per;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    // A released pin is pulled up by the receiver.
    wire         pin = demand_oe ? demand_o : 1'b1;

    always #4 clk_sys = ~clk_sys;

    // A short period (two clocks a step) keeps each PWM measurement cheap.
    pdp_top #(.PWM_PERIOD_CYC(2000)) pdp_top_inst (
        .CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PEDAL_TORQUE(pedal), .CRUISE_TORQUE(cruise), .ROAD_LIMIT_REDUCTION(red),
        .AVAIL_TORQUE(avail), .DEMAND_OUTPUT_PORT_O(demand_o),
        .DEMAND_OUTPUT_PORT_OE(demand_oe));

    pdp_rx pdp_rx_inst (
        .clk(clk_sys), .rst(reset), .pin(pin), .hi_len(hi_len), .per_len(per_len),
        .n_per(n_per));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_dem(input logic [15:0] p, c, r, v);
        @(posedge clk_sys);
        pedal <= p;
        cruise <= c;
        red <= r;
        avail <= v;
        repeat (60) @(posedge clk_sys);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        apb(1'b0, `PDP_ADDR_CTRL, 32'h0, q, e);
        `CHK("ctrl reset", 32'h0, q)
        apb(1'b0, `PDP_ADDR_CAL, 32'h0, q, e);
        `CHK("cal reset", 32'h00C8_0320, q)
        apb(1'b0, 8'h10, 32'h0, q, e);
        `CHK("unmapped err", 1'b1, e)
        apb(1'b1, `PDP_ADDR_DUTY, 32'hFFFF_FFFF, q, e);
        `CHK("read-only err", 1'b1, e)
    endtask

    task automatic dem_chk(input logic [15:0] p, c, r, v, input logic [9:0] x);
        logic [31:0] q;
        logic        e;
        set_dem(p, c, r, v);
        apb(1'b0, `PDP_ADDR_STATUS, 32'h0, q, e);
        `CHK("demand", x, q[9:0])
    endtask

    task automatic mod_chk(input logic [31:0] ctrl, input logic [15:0] p, input logic [9:0] dx);
        logic [31:0] q;
        logic        e;
        int          n0;
        int          k;
        apb(1'b1, `PDP_ADDR_CTRL, ctrl, q, e);
        set_dem(p, 16'h0, 16'h0, 16'h03E8);
        n0 = n_per;
        k = 0;
        while (n_per != n0 + 3 && k < 8000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 8000) n_mismatch++;
        `CHK("high clocks", {5'h00, dx, 1'b0}, hi_len)
        `CHK("period clocks", 16'h07D0, per_len)
        apb(1'b0, `PDP_ADDR_DUTY, 32'h0, q, e);
        `CHK("duty", dx, q[9:0])
    endtask

    task automatic disc_chk(input logic [15:0] p, input logic x);
        set_dem(p, 16'h0, 16'h0, 16'h03E8);
        `CHK("discrete pin", x, demand_oe)
    endtask

    task automatic t_disc;
        logic [31:0] q;
        logic        e;
        apb(1'b1, `PDP_ADDR_CTRL, 32'h3, q, e);
        repeat (2100) @(posedge clk_sys);
        disc_chk(16'h0000, 1'b0);
        disc_chk(16'h0316, 1'b0);
        disc_chk(16'h0320, 1'b1);
        disc_chk(16'h0258, 1'b1);
        disc_chk(16'h0257, 1'b0);
        disc_chk(16'h02BC, 1'b0);
        apb(1'b1, `PDP_ADDR_CAL, 32'h0064_01F4, q, e);
        disc_chk(16'h01F4, 1'b1);
        disc_chk(16'h0190, 1'b1);
        disc_chk(16'h018F, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        dem_chk(16'h012C, 16'h0, 16'h0, 16'h03E8, 10'h12C);
        dem_chk(16'h012C, 16'h0064, 16'h0, 16'h07D0, 10'h0C8);
        dem_chk(16'h012C, 16'h0064, 16'h0032, 16'h03E8, 10'h15E);
        dem_chk(16'h0064, 16'h0, 16'h00C8, 16'h03E8, 10'h000);
        dem_chk(16'h07D0, 16'h0, 16'h0, 16'h03E8, 10'h3E8);
        dem_chk(16'h0001, 16'h0, 16'h0, 16'h0003, 10'h14D);
        dem_chk(16'h0005, 16'h0, 16'h0, 16'h0000, 10'h000);
        mod_chk(32'h1, 16'h00FA, 10'h0FA);
        mod_chk(32'h5, 16'h00FA, 10'h113);
        mod_chk(32'h5, 16'h0000, 10'h032);
        mod_chk(32'h5, 16'h03E8, 10'h3B6);
        mod_chk(32'h1, 16'h03E7, 10'h3E7);
        t_disc();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        summarize();
    end
endmodule // test_powertrain_demand_pwm_output

// file: verilog/pdp_div.v
`timescale 1ns/1ns
// Restoring divider, one quotient bit per clock, done pulses after WN clocks.
module pdp_div #(
    parameter integer WN = 26,
    parameter integer WD = 16
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          start,
    input  wire [WN-1:0] num,
    input  wire [WD-1:0] den,
    output reg  [WN-1:0] quo_r,
    output reg           busy_r,
    output reg           done_r
);
    reg  [WD:0]   rem_r;
    reg  [WD-1:0] den_r;
    reg  [5:0]    cnt_r;
    wire [WD:0]   shifted = {rem_r[WD-1:0], quo_r[WN-1]};
    wire          fits    = shifted >= {1'b0, den_r};

    always @(posedge clk) begin
        if (rst) begin
            quo_r  <= {WN{1'b0}};
            rem_r  <= {(WD+1){1'b0}};
            den_r  <= {WD{1'b0}};
            cnt_r  <= 6'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (start && !busy_r) begin
            quo_r  <= num;
            rem_r  <= {(WD+1){1'b0}};
            den_r  <= den;
            cnt_r  <= WN[5:0];
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (busy_r) begin
            rem_r  <= fits ? (shifted - {1'b0, den_r}) : shifted;
            quo_r  <= {quo_r[WN-2:0], fits};
            cnt_r  <= cnt_r - 6'h01;
            busy_r <= (cnt_r != 6'h01);
            done_r <= (cnt_r == 6'h01);
        end else begin
            done_r <= 1'b0;
        end
    end
endmodule // pdp_div

// file: verilog/pdp_map.vh
`ifndef PDP_MAP_VH
`define PDP_MAP_VH

// Register byte addresses on the APB port.
`define PDP_ADDR_CTRL        8'h00
`define PDP_ADDR_CAL         8'h04
`define PDP_ADDR_STATUS      8'h08
`define PDP_ADDR_DUTY        8'h0C

// Control register fields.
`define PDP_CTRL_EN          0
`define PDP_CTRL_MODE        1
`define PDP_CTRL_SPAN        2
`define PDP_CTRL_RST         3'h0
`define PDP_CTRL_BITS        2:0

// Calibration register fields and reset values, in tenths of a percent.
`define PDP_CAL_ON           9:0
`define PDP_CAL_HYST         25:16
`define PDP_CAL_ON_RST       10'h320
`define PDP_CAL_HYST_RST     10'h0C8

// Status and duty register fields.
`define PDP_STAT_DEMAND      9:0
`define PDP_STAT_ON          16
`define PDP_STAT_OE          17
`define PDP_DUTY_APPLIED     9:0
`define PDP_DUTY_MODE        16

// Demand scale: 1000 steps make full demand and one full period.
`define PDP_SCALE            10'h3E8
`define PDP_LAST_STEP        10'h3E7
`define PDP_SCALE_INT        1000

// Limited span: 5 % floor plus demand times nine tenths.
`define PDP_LIM_FLOOR        10'h032
`define PDP_LIM_MUL          4'h9
`define PDP_DIV10_MUL        13'h199A
`define PDP_DIV10_HI         25
`define PDP_DIV10_LO         16

// Timing: clock period and output period in nanoseconds.
`define PDP_CLK_NS           8
`define PDP_PERIOD_NS        20000000

`endif

// file: verilog/pdp_tick.v
`timescale 1ns/1ns
// Free-running divider that emits a one-cycle enable every DIV clocks.
module pdp_tick #(
    parameter integer DIV = 2500
) (
    input  wire       clk,
    input  wire       rst,
    output reg        tick_r
);
    // Counter is 12 bits wide, so DIV must stay at or below 4096.
    localparam [11:0] LAST = DIV[11:0] - 12'h001;

    reg  [11:0] cnt_r;

    always @(posedge clk) begin
        if (rst) begin
            cnt_r  <= 12'h000;
            tick_r <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r  <= 12'h000;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 12'h001;
            tick_r <= 1'b0;
        end
    end
endmodule // pdp_tick

// file: verilog/pdp_top.v
`timescale 1ns/1ns
`include "pdp_map.vh"

module pdp_top #(
    parameter integer PWM_PERIOD_CYC = `PDP_PERIOD_NS / `PDP_CLK_NS
) (
    input  wire        CLK_SYS,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [15:0] PEDAL_TORQUE,
    input  wire [15:0] CRUISE_TORQUE,
    input  wire [15:0] ROAD_LIMIT_REDUCTION,
    input  wire [15:0] AVAIL_TORQUE,
    output reg         DEMAND_OUTPUT_PORT_O,
    output reg         DEMAND_OUTPUT_PORT_OE
);

    // One period is split into 1000 steps; each step lasts STEP_CYC clocks.
    localparam integer STEP_CYC = PWM_PERIOD_CYC / `PDP_SCALE_INT;

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers
    ////////////////////////////////////////////////////////////////////////////////

    reg  [2:0]  ctrl_r;
    reg  [9:0]  cal_on_r;
    reg  [9:0]  cal_hyst_r;

    wire        acc_setup = PSEL && !PENABLE;
    wire        acc_done  = PSEL && PENABLE && PREADY;
    wire        wr_en     = acc_done && PWRITE;

    reg         addr_ok;

    always @* begin
        case (PADDR)
            `PDP_ADDR_CTRL:   addr_ok = 1'b1;
            `PDP_ADDR_CAL:    addr_ok = 1'b1;
            `PDP_ADDR_STATUS: addr_ok = 1'b1;
            `PDP_ADDR_DUTY:   addr_ok = 1'b1;
            default:          addr_ok = 1'b0;
        endcase
    end

    // Status registers are read-only; writes to them answer as errors.
    wire        wr_ro = (PADDR == `PDP_ADDR_STATUS) || (PADDR == `PDP_ADDR_DUTY);

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            ctrl_r     <= `PDP_CTRL_RST;
            cal_on_r   <= `PDP_CAL_ON_RST;
            cal_hyst_r <= `PDP_CAL_HYST_RST;
        end else if (wr_en) begin
            case (PADDR)
                `PDP_ADDR_CTRL: begin
                    ctrl_r <= PWDATA[`PDP_CTRL_BITS];
                end
                `PDP_ADDR_CAL: begin
                    cal_on_r   <= PWDATA[`PDP_CAL_ON];
                    cal_hyst_r <= PWDATA[`PDP_CAL_HYST];
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operating torque and demand
    ////////////////////////////////////////////////////////////////////////////////

    // Only pedal, cruise and the road-speed reduction enter the sum. The hand
    // throttle, idle and rated-speed governors and the emission and protection
    // reductions never reach this block, so they cannot bias the demand.
    wire [17:0] op_sum = {2'b00, PEDAL_TORQUE}
                       + {2'b00, CRUISE_TORQUE}
                       - {2'b00, ROAD_LIMIT_REDUCTION};
    // Reductions beyond the requested torque give zero demand, and requests
    // beyond a nonzero available torque are held at full demand.
    wire        op_neg  = op_sum[17];
    wire        op_over = !op_neg && (op_sum[16:0] > {1'b0, AVAIL_TORQUE});
    wire [15:0] op_clip = op_neg  ? 16'h0000 :
                          op_over ? AVAIL_TORQUE : op_sum[15:0];
    // Both divider operands are captured in the same clock; this also takes
    // the 16 by 10 product out of the divider's load path. A torque step thus
    // reaches the status demand in under 60 clocks.
    reg  [25:0] div_num_r;
    reg  [15:0] avail_r;

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            div_num_r <= 26'h0000000;
            avail_r   <= 16'h0000;
        end else begin
            div_num_r <= op_clip * `PDP_SCALE;
            avail_r   <= AVAIL_TORQUE;
        end
    end

    wire [25:0] div_quo;
    wire        div_busy;
    wire        div_done;
    reg         div_start_r;
    reg         avail_zero_r;

    pdp_div #(
        .WN     (26),
        .WD     (16)
    ) u_div (
        .clk    (CLK_SYS),
        .rst    (RESET),
        .start  (div_start_r),
        .num    (div_num_r),
        .den    (avail_r),
        .quo_r  (div_quo),
        .busy_r (div_busy),
        .done_r (div_done)
    );

    // The divider reruns back to back, so the demand trails the torque inputs
    // by 29 to 56 clocks, far below one output step at the default STEP_CYC of 2500 clocks.
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            div_start_r  <= 1'b0;
            avail_zero_r <= 1'b0;
        end else begin
            div_start_r  <= !div_busy && !div_start_r;
            if (div_start_r && !div_busy) begin
                avail_zero_r <= (avail_r == 16'h0000);
            end
        end
    end

    reg  [9:0]  demand_r;

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            demand_r <= 10'h000;
        end else if (div_done) begin
            if (avail_zero_r) begin
                demand_r <= 10'h000;
            end else if (div_quo > {16'h0000, `PDP_SCALE}) begin
                demand_r <= `PDP_SCALE;
            end else begin
                demand_r <= div_quo[9:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Discrete on/off with hysteresis
    ////////////////////////////////////////////////////////////////////////////////

    // A hysteresis wider than the threshold clamps the release point at zero;
    // demand never falls below zero, so the output then never releases.
    reg  [9:0]  off_thr_r;
    reg         on_r;

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            off_thr_r <= `PDP_CAL_ON_RST - `PDP_CAL_HYST_RST;
        end else if (cal_hyst_r > cal_on_r) begin
            off_thr_r <= 10'h000;
        end else begin
            off_thr_r <= cal_on_r - cal_hyst_r;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            on_r <= 1'b0;
        end else if (demand_r >= cal_on_r) begin
            on_r <= 1'b1;
        end else if (demand_r < off_thr_r) begin
            on_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Duty mapping
    ////////////////////////////////////////////////////////////////////////////////

    // Nine tenths of demand is formed as 9*d times 6554 over 65536, which is
    // exact for every demand up to full scale and avoids a second divider.
    wire [13:0] dem_x9   = demand_r * `PDP_LIM_MUL;
    wire [26:0] dem_x9d  = dem_x9 * `PDP_DIV10_MUL;
    wire [9:0]  lim_duty = `PDP_LIM_FLOOR
                         + dem_x9d[`PDP_DIV10_HI:`PDP_DIV10_LO];
    wire [9:0]  duty_nxt = ctrl_r[`PDP_CTRL_SPAN] ? lim_duty : demand_r;

    // The span multiply is registered to ease timing, and the mode and enable
    // bits with it, so every setting taken at a period end is from one clock.
    // A write in the clock just before a period end therefore waits a period.
    reg  [9:0]  duty_calc_r;
    reg  [2:0]  ctrl_q_r;

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            duty_calc_r <= 10'h000;
            ctrl_q_r    <= `PDP_CTRL_RST;
        end else begin
            duty_calc_r <= duty_nxt;
            ctrl_q_r    <= ctrl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // 50 Hz period and output
    ////////////////////////////////////////////////////////////////////////////////

    wire        step_tick;

    pdp_tick #(
        .DIV    (STEP_CYC)
    ) u_step (
        .clk    (CLK_SYS),
        .rst    (RESET),
        .tick_r (step_tick)
    );

    reg  [9:0]  step_r;
    reg  [9:0]  duty_r;
    reg         mode_r;
    reg         en_r;
    wire        period_end = step_tick && (step_r == `PDP_LAST_STEP);

    // Duty, mode and enable are sampled only at the period boundary, so a modulated pulse
    // is never cut short or stretched by a software write in mid-period.
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            step_r <= 10'h000;
            duty_r <= 10'h000;
            mode_r <= 1'b0;
            en_r   <= 1'b0;
        end else if (period_end) begin
            step_r <= 10'h000;
            duty_r <= duty_calc_r;
            mode_r <= ctrl_q_r[`PDP_CTRL_MODE];
            en_r   <= ctrl_q_r[`PDP_CTRL_EN];
        end else if (step_tick) begin
            step_r <= step_r + 10'h001;
        end
    end

    // The pin is open drain: grounding it is the on state; when released the
    // far side's pull-up makes it high. In modulated mode the released part
    // of each period is the duty.
    reg         oe_nxt;

    always @* begin
        if (!en_r) begin
            oe_nxt = 1'b0;
        end else if (mode_r) begin
            oe_nxt = on_r;
        end else begin
            oe_nxt = !(step_r < duty_r);
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            DEMAND_OUTPUT_PORT_O  <= 1'b0;
            DEMAND_OUTPUT_PORT_OE <= 1'b0;
        end else begin
            DEMAND_OUTPUT_PORT_O  <= 1'b0;
            DEMAND_OUTPUT_PORT_OE <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer
    ////////////////////////////////////////////////////////////////////////////////

    reg  [31:0] rd_nxt;

    always @* begin
        rd_nxt = 32'h00000000;
        case (PADDR)
            `PDP_ADDR_CTRL: begin
                rd_nxt[`PDP_CTRL_BITS] = ctrl_r;
            end
            `PDP_ADDR_CAL: begin
                rd_nxt[`PDP_CAL_ON]   = cal_on_r;
                rd_nxt[`PDP_CAL_HYST] = cal_hyst_r;
            end
            `PDP_ADDR_STATUS: begin
                rd_nxt[`PDP_STAT_DEMAND] = demand_r;
                rd_nxt[`PDP_STAT_ON]     = on_r;
                rd_nxt[`PDP_STAT_OE]     = DEMAND_OUTPUT_PORT_OE;
            end
            `PDP_ADDR_DUTY: begin
                rd_nxt[`PDP_DUTY_APPLIED] = duty_r;
                rd_nxt[`PDP_DUTY_MODE]    = mode_r;
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    // Answer is prepared in the setup cycle, so every transfer completes in
    // its first access cycle with no wait state.
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else if (acc_setup) begin
            PREADY  <= 1'b1;
            PRDATA  <= PWRITE ? 32'h00000000 : rd_nxt;
            PSLVERR <= !addr_ok || (PWRITE && wr_ro);
        end else begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end
    end

endmodule // pdp_top
